// ---- dcffm_pkg.sv ----
// package of the two-clock fifo flags and mailbox block
// holds widths, reset values, port sample structs and the offset load states
// assumes all users import it whole
package dcffm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned DATA_W      = 36;       // data word and mail width
  localparam int unsigned PTR_W       = 12;       // pointer width, covers 2 x 2048
  localparam int unsigned OFS_W       = 11;       // offset width, covers 2047
  localparam int unsigned STAGE_DEPTH = 8;        // words in the write staging fifo
  localparam int unsigned DEPTH_512   = 512;      // smallest depth choice
  localparam int unsigned DEPTH_1024  = 1024;     // middle depth choice
  localparam int unsigned DEPTH_2048  = 2048;     // largest depth choice

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RST_WRITE_SPACE = 1'b0;        // no writes until offsets are loaded
  localparam logic RST_NEAR_FULL_N = 1'b1;
  localparam logic RST_OUT_READY   = 1'b0;
  localparam logic RST_NEAR_EMPT_N = 1'b0;
  localparam logic RST_MAIL_FLAG_N = 1'b1;        // high means the mail register is free

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [PTR_W-1:0]  dcffm_ptr_t;
  typedef logic [DATA_W-1:0] dcffm_word_t;
  typedef logic [OFS_W-1:0]  dcffm_ofs_t;

  // offset loading progress after reset
  typedef enum logic [1:0] {
    LOAD_NEAR_EMPTY,
    LOAD_NEAR_FULL,
    LOAD_DONE
  } dcffm_load_e;

  // control pins of one port
  typedef struct packed {
    logic cs_n;                                   // chip select, active low
    logic dir;                                    // a: high writes, b: high reads
    logic en;                                     // transfer enable
    logic mb;                                     // mail select
  } dcffm_port_s;

  // every asynchronous pin, sampled together
  typedef struct packed {
    logic        clk_a;
    logic        clk_b;
    dcffm_port_s port_a;
    dcffm_port_s port_b;
    logic        retransmit_mode_in;
    logic        replay_from_marker_in;
    dcffm_word_t bus_a;
    dcffm_word_t bus_b;
  } dcffm_pins_s;

endpackage

// ---- dcffm_top.sv ----
// write staging fifo and the flags, retransmit and mailbox core of the block
// assumes both port clocks are much slower than i_ref_clk (below a quarter of it)
// and that all port pins arrive asynchronously to i_ref_clk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// small staging fifo between the port-a write and the main memory
module dcffm_stage_fifo
  import dcffm_pkg::*;
#(
  parameter int unsigned W     = 36,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } dcffm_stage_s;

  dcffm_stage_s  q;
  dcffm_stage_s  d;
  logic [W-1:0]  mem [DEPTH];
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  // honest full and empty from the extra pointer bit
  assign full  = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign empty = (q.wr == q.rd);
  assign push  = i_in_valid && !full;
  assign pop   = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[q.rd[AW-1:0]];

  // pointer advance
  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[q.wr[AW-1:0]] <= i_in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - flags from stored count: empty, near-empty, near-full and full ranges set flags
// - near-empty threshold is offset x, near-full distance from full is offset y
// - word in output register is not counted and its location is free
// - first word into empty fifo falls to output register unrequested
// - replay in retransmit mode reloads read pointer from shadow, output ready at once
// - near-empty rises within two port-b edges after a replay lifts the level
// - leaving retransmit switches full-side flags from shadow to current pointer
// - full-side flag change on exit passes two port-a synchronizing edges
// - two 36-bit mail registers, one each way, chosen by mail select
// - port-a write with mail select loads the a-to-b mail register
// - port-b write with mail select loads the b-to-a mail register
// - an accepted mail write drives that mail flag low
// - mail writes are dropped while the mail flag is low
// - port-b bus shows output register, or a-to-b mail when selected
// - port-a bus always shows the b-to-a mail register
// - port-b mail read sets the a-to-b mail flag high
// - port-a mail read sets the b-to-a mail flag high
// - reads leave mail contents untouched
// - offsets load by port-a writes without mail select, gaps allowed
// - fifo writes are ignored until write space flag goes high
// - first word reaches output within three or four port-b edges
// - retransmit is steered by retransmit and replay inputs only
// - retransmit entered with ready output word, held until mode input low
// - near-empty low at x or fewer words, high at x plus one
module dcffm_top
  import dcffm_pkg::*;
#(
  parameter int unsigned DEPTH = 512                       // 512, 1024 or 2048
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_port_a_clock,
  input  wire logic        i_port_a_chip_select_n,
  input  wire logic        i_port_a_direction,
  input  wire logic        i_port_a_enable,
  input  wire logic        i_port_a_mail_select,
  input  wire dcffm_word_t i_port_a_bus_in,
  output dcffm_word_t      o_port_a_bus_out,
  output logic             o_port_a_bus_oe,
  input  wire logic        i_port_b_clock,
  input  wire logic        i_port_b_chip_select_n,
  input  wire logic        i_port_b_direction,
  input  wire logic        i_port_b_enable,
  input  wire logic        i_port_b_mail_select,
  input  wire dcffm_word_t i_port_b_bus_in,
  output dcffm_word_t      o_port_b_bus_out,
  output logic             o_port_b_bus_oe,
  input  wire logic        i_retransmit_mode_in,
  input  wire logic        i_replay_from_marker_in,
  output logic             o_write_space_flag,
  output logic             o_near_full_flag_n,
  output logic             o_output_ready,
  output logic             o_near_empty_flag_n,
  output logic             o_mail_to_b_flag_n,
  output logic             o_mail_to_a_flag_n
);
  localparam int unsigned AW      = $clog2(DEPTH);
  localparam dcffm_ptr_t  DEPTH_P = PTR_W'(DEPTH);
  localparam dcffm_ptr_t  ONE_P   = PTR_W'(1);

  typedef struct packed {
    dcffm_pins_s s1;                               // first synchroniser stage
    dcffm_pins_s s2;                               // second synchroniser stage
    logic        clk_a_prev;
    logic        clk_b_prev;
    dcffm_load_e load;
    dcffm_ofs_t  ofs_x;
    dcffm_ofs_t  ofs_y;
    dcffm_ptr_t  wacc;                             // words accepted from port a
    dcffm_ptr_t  wptr;                             // words placed in memory
    dcffm_ptr_t  rptr;                             // current read pointer
    dcffm_ptr_t  shadow;                           // retransmit start location
    dcffm_ptr_t  w_gray;
    dcffm_ptr_t  w_gray_b1;
    dcffm_ptr_t  w_gray_b2;
    dcffm_ptr_t  r_gray;
    dcffm_ptr_t  r_gray_a1;
    dcffm_ptr_t  r_gray_a2;
    logic        rt_mode;
    dcffm_word_t out_word;
    logic        out_valid;
    dcffm_word_t mail_b;                           // a-to-b mail
    dcffm_word_t mail_a;                           // b-to-a mail
    logic        mail_b_n;
    logic        mail_a_n;
    logic        ir;
    logic        nf_n;
    logic        ne_n;
    dcffm_word_t a_out;
    logic        a_oe;
    dcffm_word_t b_out;
    logic        b_oe;
  } dcffm_state_s;

  dcffm_state_s q;
  dcffm_state_s d;
  dcffm_word_t  mem [DEPTH];
  dcffm_pins_s  pins;
  logic         st_in_valid;
  logic         st_in_ready;
  logic         st_out_valid;
  logic         st_out_ready;
  dcffm_word_t  st_out_data;
  logic         mem_we;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic dcffm_ptr_t bin2gray(input dcffm_ptr_t b);
    return b ^ (b >> 1);
  endfunction

  function automatic dcffm_ptr_t gray2bin(input dcffm_ptr_t g);
    dcffm_ptr_t b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [AW-1:0] addr_of(input dcffm_ptr_t p);
    return p[AW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // gather asynchronous pins
  always_comb begin
    pins.clk_a  = i_port_a_clock;
    pins.clk_b  = i_port_b_clock;
    pins.port_a = '{cs_n: i_port_a_chip_select_n, dir: i_port_a_direction,
                    en: i_port_a_enable, mb: i_port_a_mail_select};
    pins.port_b = '{cs_n: i_port_b_chip_select_n, dir: i_port_b_direction,
                    en: i_port_b_enable, mb: i_port_b_mail_select};
    pins.retransmit_mode_in    = i_retransmit_mode_in;
    pins.replay_from_marker_in    = i_replay_from_marker_in;
    pins.bus_a  = i_port_a_bus_in;
    pins.bus_b  = i_port_b_bus_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write staging, stalls when the memory itself is full
  dcffm_stage_fifo #(
    .W     (DATA_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (st_in_valid),
    .o_in_ready  (st_in_ready),
    .i_in_data   (q.s2.bus_a),
    .o_out_valid (st_out_valid),
    .i_out_ready (st_out_ready),
    .o_out_data  (st_out_data)
  );

  assign mem_we = st_out_valid && st_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    dcffm_port_s pa;
    dcffm_port_s pb;
    logic        a_edge;
    logic        b_edge;
    logic        a_wr;
    logic        a_rd;
    logic        b_wr;
    logic        b_rd;
    logic        accept;
    logic        replay;
    dcffm_ptr_t  ra;
    dcffm_ptr_t  wb;
    dcffm_ptr_t  cnt_a;
    dcffm_ptr_t  cnt_b;
    dcffm_ptr_t  rsel;
    d       = q;
    pa      = q.s2.port_a;
    pb      = q.s2.port_b;
    replay  = 1'b0;
    // pins pass two flops; only the second is read by logic
    d.s1 = pins;
    d.s2 = q.s1;
    d.clk_a_prev = q.s2.clk_a;
    d.clk_b_prev = q.s2.clk_b;
    a_edge = q.s2.clk_a && !q.clk_a_prev;
    b_edge = q.s2.clk_b && !q.clk_b_prev;
    a_wr = a_edge && !pa.cs_n && pa.en && pa.dir;
    a_rd = a_edge && !pa.cs_n && pa.en && !pa.dir;
    b_rd = b_edge && !pb.cs_n && pb.en && pb.dir;
    b_wr = b_edge && !pb.cs_n && pb.en && !pb.dir;

    // pointer views across the two sides, gray coded
    ra    = gray2bin(q.r_gray_a2);
    wb    = gray2bin(q.w_gray_b2);
    cnt_a = q.wacc - ra;
    st_in_valid  = a_wr && !pa.mb && (q.load == LOAD_DONE) && q.ir;
    accept       = st_in_valid && st_in_ready;
    st_out_ready = (q.wptr - ra) < DEPTH_P;
    if (accept) begin
      d.wacc = q.wacc + ONE_P;
    end
    if (mem_we) begin
      d.wptr = q.wptr + ONE_P;
    end
    d.w_gray = bin2gray(q.wptr);
    // full side watches the shadow pointer while retransmitting
    rsel     = q.rt_mode ? q.shadow : q.rptr;
    d.r_gray = bin2gray(rsel);

    // offset loading, gaps between steps are fine
    if (a_wr && !pa.mb) begin
      unique case (q.load)
      LOAD_NEAR_EMPTY: begin
        d.ofs_x = q.s2.bus_a[OFS_W-1:0];
        d.load  = LOAD_NEAR_FULL;
      end
      LOAD_NEAR_FULL: begin
        d.ofs_y = q.s2.bus_a[OFS_W-1:0];
        d.load  = LOAD_DONE;
      end
      LOAD_DONE: begin
        d.load = LOAD_DONE;
      end
      endcase
    end

    // port-a side flags, two port-a edges behind the read side
    if (a_edge) begin
      d.r_gray_a1 = q.r_gray;
      d.r_gray_a2 = q.r_gray_a1;
      if (accept) begin
        cnt_a = cnt_a + ONE_P;
      end
      d.ir   = (q.load == LOAD_DONE) && (cnt_a < DEPTH_P) && st_in_ready;
      d.nf_n = !(cnt_a >= (DEPTH_P - PTR_W'(q.ofs_y)));
    end

    // port-b side: retransmit, fall through and reads
    if (b_edge) begin
      d.w_gray_b1 = q.w_gray;
      d.w_gray_b2 = q.w_gray_b1;
      // only the mode and replay inputs steer retransmit
      if (q.rt_mode) begin
        if (!q.s2.retransmit_mode_in) begin
          d.rt_mode = 1'b0;
        end else if (q.s2.replay_from_marker_in) begin
          replay      = 1'b1;
          d.out_word  = mem[addr_of(q.shadow)];
          d.rptr      = q.shadow + ONE_P;
          d.out_valid = 1'b1;
        end
      end else if (q.s2.retransmit_mode_in && q.out_valid) begin
        d.rt_mode = 1'b1;
        d.shadow  = q.rptr - ONE_P;                                      // marks the output word
      end
      if (!replay && (!q.out_valid || (b_rd && !pb.mb))) begin
        if ((wb - q.rptr) != '0) begin
          d.out_word  = mem[addr_of(q.rptr)];
          d.rptr      = q.rptr + ONE_P;                                  // location freed
          d.out_valid = 1'b1;
        end else begin
          d.out_valid = 1'b0;
        end
      end
      // output word is not counted
      cnt_b  = wb - d.rptr;
      d.ne_n = cnt_b > PTR_W'(q.ofs_x);
    end

    // mail flags: reads free the register, writes win a tie only when the flag was already high
    if (b_rd && pb.mb) begin
      d.mail_b_n = 1'b1;
    end
    if (a_rd && pa.mb) begin
      d.mail_a_n = 1'b1;
    end
    if (a_wr && pa.mb && q.mail_b_n) begin
      d.mail_b   = q.s2.bus_a;
      d.mail_b_n = 1'b0;
    end
    if (b_wr && pb.mb && q.mail_a_n) begin
      d.mail_a   = q.s2.bus_b;
      d.mail_a_n = 1'b0;
    end

    // bus drive
    d.a_out = q.mail_a;
    d.a_oe  = !pa.cs_n && !pa.dir;
    d.b_out = pb.mb ? q.mail_b : q.out_word;
    d.b_oe  = !pb.cs_n && pb.dir;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q          <= '0;
      q.load     <= LOAD_NEAR_EMPTY;
      q.mail_b_n <= RST_MAIL_FLAG_N;
      q.mail_a_n <= RST_MAIL_FLAG_N;
      q.ir       <= RST_WRITE_SPACE;
      q.nf_n     <= RST_NEAR_FULL_N;
      q.ne_n     <= RST_NEAR_EMPT_N;
      q.out_valid <= RST_OUT_READY;
    end else begin
      q <= d;
    end
  end

  // main storage, no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem[addr_of(q.wptr)] <= st_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign o_port_a_bus_out    = q.a_out;
  assign o_port_a_bus_oe     = q.a_oe;
  assign o_port_b_bus_out    = q.b_out;
  assign o_port_b_bus_oe     = q.b_oe;
  assign o_write_space_flag  = q.ir;
  assign o_near_full_flag_n  = q.nf_n;
  assign o_output_ready      = q.out_valid;
  assign o_near_empty_flag_n = q.ne_n;
  assign o_mail_to_b_flag_n  = q.mail_b_n;
  assign o_mail_to_a_flag_n  = q.mail_a_n;
endmodule

// ---- dcffm_top_chk.sv ----
// concurrent checks on the pins of the fifo flags and mailbox block
// assumes port pins are held stable for several ref cycles around each port edge
`timescale 1ns/1ps
module dcffm_chk
  import dcffm_pkg::*;
#(
  parameter int unsigned DEPTH = 512
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_port_a_clock,
  input wire logic        i_port_a_chip_select_n,
  input wire logic        i_port_a_direction,
  input wire logic        i_port_a_enable,
  input wire logic        i_port_a_mail_select,
  input wire dcffm_word_t i_port_a_bus_in,
  input wire dcffm_word_t o_port_a_bus_out,
  input wire logic        o_port_a_bus_oe,
  input wire logic        i_port_b_clock,
  input wire logic        i_port_b_chip_select_n,
  input wire logic        i_port_b_direction,
  input wire logic        i_port_b_enable,
  input wire logic        i_port_b_mail_select,
  input wire dcffm_word_t i_port_b_bus_in,
  input wire dcffm_word_t o_port_b_bus_out,
  input wire logic        o_port_b_bus_oe,
  input wire logic        i_retransmit_mode_in,
  input wire logic        i_replay_from_marker_in,
  input wire logic        o_write_space_flag,
  input wire logic        o_near_full_flag_n,
  input wire logic        o_output_ready,
  input wire logic        o_near_empty_flag_n,
  input wire logic        o_mail_to_b_flag_n,
  input wire logic        o_mail_to_a_flag_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // decoded mail transfers at the pins
  logic wr_mail_a, rd_mail_a, wr_mail_b, rd_mail_b;
  assign wr_mail_a = !i_port_a_chip_select_n && i_port_a_direction && i_port_a_enable && i_port_a_mail_select;
  assign rd_mail_a = !i_port_a_chip_select_n && !i_port_a_direction && i_port_a_enable && i_port_a_mail_select;
  assign wr_mail_b = !i_port_b_chip_select_n && !i_port_b_direction && i_port_b_enable && i_port_b_mail_select;
  assign rd_mail_b = !i_port_b_chip_select_n && i_port_b_direction && i_port_b_enable && i_port_b_mail_select;

  ////////////////////////////////////////////////////////////////////////////
  // mail flags move only on their own transfers
  mail_b_set_a: assert property ($fell(o_mail_to_b_flag_n) |-> $past(wr_mail_a, 2))
    else $error("a-to-b mail flag fell without a port-a mail write");
  mail_b_clr_a: assert property ($rose(o_mail_to_b_flag_n) |-> $past(rd_mail_b, 2))
    else $error("a-to-b mail flag rose without a port-b mail read");
  mail_a_set_a: assert property ($fell(o_mail_to_a_flag_n) |-> $past(wr_mail_b, 2))
    else $error("b-to-a mail flag fell without a port-b mail write");
  mail_a_clr_a: assert property ($rose(o_mail_to_a_flag_n) |-> $past(rd_mail_a, 2))
    else $error("b-to-a mail flag rose without a port-a mail read");
  mail_hold_a: assert property ($changed(o_port_a_bus_out) |-> !$past(o_mail_to_a_flag_n))
    else $error("port-a bus changed without a new b-to-a mail");

  // flag ranges and output enables
  empty_flags_a: assert property (!o_output_ready |-> !o_near_empty_flag_n)
    else $error("near-empty high while fifo is empty");
  no_space_a: assert property (!o_output_ready && !o_write_space_flag |=> !o_output_ready)
    else $error("word appeared while writes were refused");
  b_drive_a: assert property ((!i_port_b_chip_select_n && i_port_b_direction)[*5] |-> o_port_b_bus_oe)
    else $error("port-b bus not driven during a read select");
  a_quiet_a: assert property (i_port_a_chip_select_n[*5] |-> !o_port_a_bus_oe)
    else $error("port-a bus driven while deselected");

  // main scenarios reached
  cover property ($fell(o_mail_to_b_flag_n));
  cover property (!o_write_space_flag && o_output_ready);
  cover property ($rose(o_near_empty_flag_n));
endmodule

bind dcffm_top dcffm_chk #(.DEPTH(DEPTH)) chk_u (
  .i_ref_clk, .i_rst_n, .i_port_a_clock, .i_port_a_chip_select_n, .i_port_a_direction,
  .i_port_a_enable, .i_port_a_mail_select, .i_port_a_bus_in, .o_port_a_bus_out, .o_port_a_bus_oe,
  .i_port_b_clock, .i_port_b_chip_select_n, .i_port_b_direction, .i_port_b_enable,
  .i_port_b_mail_select, .i_port_b_bus_in, .o_port_b_bus_out, .o_port_b_bus_oe,
  .i_retransmit_mode_in, .i_replay_from_marker_in, .o_write_space_flag, .o_near_full_flag_n,
  .o_output_ready, .o_near_empty_flag_n, .o_mail_to_b_flag_n, .o_mail_to_a_flag_n
);

// ---- dcffm_port_host.sv ----
// far-side model: free-running clocks of the two attached synchronous buses
// assumes a 20 MHz reference; port clocks are slower and out of step with it
`timescale 1ns/1ps
module dcffm_port_host #(
  parameter int HALF_NS = 200
) (
  output logic o_port_a_clock,
  output logic o_port_b_clock
);
  ////////////////////////////////////////////////////////////////////////////
  // port-a clock, offset so it never lands on a reference edge
  initial begin
    o_port_a_clock = 1'b0;
    #10;
    forever #HALF_NS o_port_a_clock = ~o_port_a_clock;
  end

  // port-b clock, lagging port a by 120 ns
  initial begin
    o_port_b_clock = 1'b0;
    #130;
    forever #HALF_NS o_port_b_clock = ~o_port_b_clock;
  end
endmodule

// ---- dcffm_top_tb.sv ----
// self-checking bench of the fifo flags, retransmit and mailbox block
// assumes the host model supplies both port clocks; depth 512, x=2, y=3
`timescale 1ns/1ps
module dcffm_top_tb;
  import dcffm_pkg::*;
  localparam dcffm_port_s OP_FIFO = 4'h6;             // fifo write on a, fifo read on b
  localparam dcffm_port_s OP_MHI  = 4'h7;             // mail write on a, mail read on b
  localparam dcffm_port_s OP_MLO  = 4'h3;             // mail read on a, mail write on b
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        ca, cb, retransmit_mode_in = 1'b0, replay_from_marker_in = 1'b0;
  dcffm_port_s pa = 4'h8, pb = 4'h8;
  dcffm_word_t ba = 36'h0, bb = 36'h0, oa, ob;
  logic        oea, oeb, ws, nf_n, ordy, ne_n, mb_n, ma_n;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  dcffm_port_host host_u (.o_port_a_clock(ca), .o_port_b_clock(cb));

  dcffm_top #(.DEPTH(512)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_port_a_clock(ca),
    .i_port_a_chip_select_n(pa.cs_n), .i_port_a_direction(pa.dir), .i_port_a_enable(pa.en),
    .i_port_a_mail_select(pa.mb), .i_port_a_bus_in(ba), .o_port_a_bus_out(oa), .o_port_a_bus_oe(oea),
    .i_port_b_clock(cb), .i_port_b_chip_select_n(pb.cs_n), .i_port_b_direction(pb.dir),
    .i_port_b_enable(pb.en), .i_port_b_mail_select(pb.mb), .i_port_b_bus_in(bb), .o_port_b_bus_out(ob),
    .o_port_b_bus_oe(oeb), .i_retransmit_mode_in(retransmit_mode_in), .i_replay_from_marker_in(replay_from_marker_in),
    .o_write_space_flag(ws), .o_near_full_flag_n(nf_n), .o_output_ready(ordy),
    .o_near_empty_flag_n(ne_n), .o_mail_to_b_flag_n(mb_n), .o_mail_to_a_flag_n(ma_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  // wide enough for a flag or two in front of a bus word
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one transfer held over a port edge; release drops the enable and inverts the bus
  task automatic xfer(input bit b, input dcffm_port_s p, input dcffm_word_t d);
    @(negedge i_ref_clk);
    if (b) begin
      pb = p;
      bb = d;
      @(posedge cb);
    end else begin
      pa = p;
      ba = d;
      @(posedge ca);
    end
    repeat (6) @(negedge i_ref_clk);
    if (b) begin
      pb.en = 1'b0;
      bb = ~d;
    end else begin
      pa.en = 1'b0;
      ba = ~d;
    end
  endtask

  // retransmit controls held over one port-b edge, no other enables
  task automatic rt(input logic m, input logic f);
    @(negedge i_ref_clk);
    retransmit_mode_in = m;
    replay_from_marker_in = f;
    @(posedge cb);
    repeat (6) @(negedge i_ref_clk);
    replay_from_marker_in = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ca);
    repeat (6) @(negedge i_ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_load();
    chk({ws, nf_n, ordy, ne_n, mb_n, ma_n}, 36'h13);
    xfer(0, OP_FIFO, 36'h2);
    idle(2);
    xfer(0, OP_FIFO, 36'h3);
    xfer(0, OP_FIFO, 36'hBAD);
    idle(4);
    chk(ws, 36'h1);
    chk(ordy, 36'h0);
  endtask

  task automatic t_fill();
    for (int k = 1; k <= 3; k++) xfer(0, OP_FIFO, 36'(k));
    idle(4);
    chk({ordy, ob}, {1'b1, 36'h1});
    chk(ne_n, 36'h0);
    xfer(0, OP_FIFO, 36'h4);
    idle(4);
    chk(ne_n, 36'h1);
    for (int k = 5; k <= 509; k++) xfer(0, OP_FIFO, 36'(k));
    idle(4);
    chk(nf_n, 36'h1);
    xfer(0, OP_FIFO, 36'd510);
    idle(4);
    chk({nf_n, ws}, 36'h1);
    for (int k = 511; k <= 513; k++) xfer(0, OP_FIFO, 36'(k));
    idle(4);
    chk(ws, 36'h0);
  endtask

  // one read first frees a location that stays free, as t_fill left no write stalled
  task automatic t_retx();
    xfer(1, OP_FIFO, 36'h0);
    rt(1'b1, 1'b0);
    for (int k = 0; k < 3; k++) xfer(1, OP_FIFO, 36'h0);
    chk(ob, 36'h5);
    rt(1'b1, 1'b1);
    chk({ordy, ob}, {1'b1, 36'h2});
    xfer(1, OP_FIFO, 36'h0);
    chk(ob, 36'h3);
    idle(4);
    chk(ws, 36'h0);
    rt(1'b0, 1'b0);
    chk(ws, 36'h0);
    idle(4);
    chk(ws, 36'h1);
  endtask

  task automatic t_mail();
    xfer(0, OP_MHI, 36'hA5A5A5A5A);
    chk(mb_n, 36'h0);
    xfer(0, OP_MHI, 36'h123456789);
    xfer(1, OP_MHI, 36'h0);
    chk({mb_n, ob}, {1'b1, 36'hA5A5A5A5A});
    xfer(1, OP_MHI, 36'h0);
    chk(ob, 36'hA5A5A5A5A);
    xfer(1, OP_MLO, 36'h0F0F0F0F0);
    chk({ma_n, oa}, {1'b0, 36'h0F0F0F0F0});
    xfer(0, OP_MLO, 36'h0);
    chk({ma_n, oea, oa}, {2'b11, 36'h0F0F0F0F0});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    t_load();
    t_fill();
    t_retx();
    t_mail();
    final_report();
  end

  initial begin
    #1000000;
    n_errors++;
    final_report();
  end
endmodule
